// ===== dv/ddr_burst2_sram_port_bench.sv
// self-checking bench: controller end facing device end
`timescale 1ns/1ps
module ddr_burst2_sram_port_bench;
  import ddrb_pkg::*;
  logic              clk_sys = 1'b0;
  logic              resetn = 1'b0;
  logic              single_clock_mode = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_read = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata0 = '0;
  logic [DATA_W-1:0] req_wdata1 = '0;
  logic [LANES-1:0]  req_lane_n0 = 4'hF;
  logic [LANES-1:0]  req_lane_n1 = 4'hF;
  logic              req_ready;
  logic              rsp_valid;
  logic              rsp_last;
  logic [DATA_W-1:0] rsp_data;
  logic              access_active;
  logic [31:0]       seed = 32'h08EAEC19;
  logic [DATA_W-1:0] mem [0:1023];
  int                errors = 0;
  int                tests_run = 0;
  int                cycles = 0;

  ddrb_link_if link();
  ddrb_ctl u_ddrb_ctl(.clk_sys(clk_sys), .resetn(resetn), .link(link), .req_valid(req_valid),
    .req_read(req_read), .req_addr(req_addr), .req_wdata0(req_wdata0),
    .req_wdata1(req_wdata1), .req_lane_n0(req_lane_n0), .req_lane_n1(req_lane_n1),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_data(rsp_data));
  ddrb_dev #(.AW(10)) u_ddrb_dev(.clk_sys(clk_sys), .resetn(resetn), .link(link),
    .single_clock_mode(single_clock_mode), .access_active(access_active));
  ddrb_assertions u_ddrb_assertions(.clk_sys(clk_sys), .resetn(resetn), .k_tick(link.k_tick),
    .load_strobe_n(link.load_strobe_n), .read_not_write(link.read_not_write),
    .byte_lane_strobe_n(link.byte_lane_strobe_n), .dq_ctl_oe(link.dq_ctl_oe),
    .dq_dev_oe(link.dq_dev_oe));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // stored word after a beat with active-low lane strobes
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, w,
                                              input logic [LANES-1:0] ln);
    merge = old;
    for (int g = 0; g < LANES; g++)
      if (!ln[g])
        merge[g*LANE_W +: LANE_W] = w[g*LANE_W +: LANE_W];
  endfunction

  task final_report;
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task req(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0, w1,
           input logic [LANES-1:0] l0, l1);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_read = rd;
    req_addr = a;
    req_wdata0 = w0;
    req_wdata1 = w1;
    req_lane_n0 = l0;
    req_lane_n1 = l1;
    n = 0;
    while (req_ready !== 1'b1 && n < 10)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    check(req_ready, 1'b0);
  endtask

  task rd_chk(input logic [9:0] a);
    logic [DATA_W-1:0] prev;
    int                n;
    req(1'b1, {12'h000, a}, '0, '0, 4'hF, 4'hF);
    n = 0;
    prev = '0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      prev = link.dq;
      @(negedge clk_sys);
      n++;
    end
    check(rsp_data, mem[a]);
    check(access_active, 1'b1);
    check(prev, mem[a]);
    check(link.dq, mem[a ^ 10'h001]);
    @(negedge clk_sys);
    check({rsp_valid, rsp_last}, 2'h3);
    check(rsp_data, mem[a ^ 10'h001]);
    repeat (2) @(negedge clk_sys);
    check(link.dq_dev_oe, 1'b0);
    check(access_active, 1'b0);
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      final_report;
    end
  end

  initial
  begin
    logic [9:0]        a;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0]  ln;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      seed = lfsr(seed);
      a = (i == 1) ? 10'h3FF : seed[9:0];
      d = {seed[3:0], seed};
      ln = (i % 4 == 0) ? 4'hF : seed[13:10];
      single_clock_mode = i[0];
      req(1'b0, {12'h000, a}, d, {d[17:0], d[35:18]}, 4'h0, 4'h0);
      mem[a] = d;
      mem[a ^ 10'h001] = {d[17:0], d[35:18]};
      seed = lfsr(seed);
      d = {seed[7:4], seed};
      req(1'b0, {12'h000, a}, ~d, d, ln, ~ln);
      mem[a] = merge(mem[a], ~d, ln);
      mem[a ^ 10'h001] = merge(mem[a ^ 10'h001], d, ~ln);
      rd_chk(a);
    end
    final_report;
  end
endmodule // ddr_burst2_sram_port_bench

// ===== dv/ddrb_assertions.sv
// link-level checks for the two-word-burst ddr sram port
`timescale 1ns/1ps
module ddrb_assertions
  import ddrb_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             resetn,
  input wire logic             k_tick,
  input wire logic             load_strobe_n,
  input wire logic             read_not_write,
  input wire logic [LANES-1:0] byte_lane_strobe_n,
  input wire logic             dq_ctl_oe,
  input wire logic             dq_dev_oe
);
  logic [3:0] rd_hist;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // read commands seen over the last four cycles
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rd_hist <= 4'h0;
    else
      rd_hist <= {rd_hist[2:0], !load_strobe_n && read_not_write};
  end

  strobe_on_true_a: assert property (!load_strobe_n |-> k_tick)
    else $error("load strobe low outside a true beat");
  strobe_pulse_a: assert property (!load_strobe_n |=> load_strobe_n)
    else $error("load strobe held low for two beats");
  write_beats_a: assert property ((!load_strobe_n && !read_not_write) |=> dq_ctl_oe[*2])
    else $error("write burst not two driven beats");
  read_beats_a: assert property ((!load_strobe_n && read_not_write) |-> ##3 dq_dev_oe[*2])
    else $error("read burst not two driven beats");
  bus_contention_a: assert property (!(dq_dev_oe && dq_ctl_oe))
    else $error("both ends drive the data wire");
  read_release_a: assert property (dq_dev_oe |-> (rd_hist[2] || rd_hist[3]))
    else $error("device drives data with no read pending");
  lane_idle_a: assert property (byte_lane_strobe_n != 4'hF |-> dq_ctl_oe)
    else $error("lane strobe active without a data beat");
  write_quiet_a: assert property ((!load_strobe_n && !read_not_write) |=> !dq_dev_oe[*2])
    else $error("device drives data during a write");
endmodule // ddrb_assertions

// ===== src/ddrb_ctl.sv
// memory controller end: drives clocks, commands and write data
`timescale 1ns/1ps
module ddrb_ctl
  import ddrb_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  ddrb_link_if.ctl                 link,
  input  wire logic                req_valid,
  input  wire logic                req_read,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata0,
  input  wire logic [DATA_W-1:0]   req_wdata1,
  input  wire logic [LANES-1:0]    req_lane_n0,
  input  wire logic [LANES-1:0]    req_lane_n1,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic                     rsp_last,
  output logic [DATA_W-1:0]        rsp_data
);
  logic                take;
  logic                last_read;
  logic [DATA_W-1:0]   wdata0;
  logic [LANES-1:0]    lane_n0;
  logic [DATA_W-1:0]   wdata1;
  logic [LANES-1:0]    lane_n1;
  logic                wr_first;
  logic                wr_second;
  logic [SH_W-1:0]     rd_sh;

  // a write right after a read would collide with the read beats
  assign take = req_valid && req_ready && !(!req_read && last_read);

  // true and complementary clock phases, one beat per system cycle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      link.k_tick  <= RST_TICK;
      link.kn_tick <= RST_TICK;
      link.c_tick  <= RST_TICK;
      link.cn_tick <= RST_TICK;
      req_ready    <= 1'b0;
    end
    else
    begin
      link.k_tick  <= ~link.k_tick;
      link.kn_tick <= link.k_tick;
      link.c_tick  <= ~link.k_tick;
      link.cn_tick <= link.k_tick;
      req_ready    <= link.k_tick;
    end
  end

  // command presented for exactly one true-clock beat
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      link.load_strobe_n     <= RST_STROBE_N;
      link.read_not_write    <= RST_RNW;
      link.addr_hi           <= '0;
      link.burst_first_index <= 1'b0;
      last_read              <= 1'b0;
    end
    else if (req_ready)
    begin
      link.load_strobe_n     <= !take; // RL4 RL13 RL14
      link.read_not_write    <= take && req_read; // RL6
      link.addr_hi           <= req_addr[ADDR_W-1:1]; // RL11
      link.burst_first_index <= req_addr[0];
      last_read              <= take && req_read;
    end
    else
    begin
      link.load_strobe_n <= RST_STROBE_N;
    end
  end

  // write beats: first on the complementary beat, second on the next true beat
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wr_first               <= 1'b0;
      wr_second              <= 1'b0;
      wdata0                 <= '0;
      lane_n0                <= RST_LANE_N;
      wdata1                 <= '0;
      lane_n1                <= RST_LANE_N;
      link.dq_ctl_o          <= '0;
      link.dq_ctl_oe         <= 1'b0;
      link.byte_lane_strobe_n <= RST_LANE_N;
    end
    else
    begin
      wr_first  <= take && !req_read;
      wr_second <= wr_first;
      // beats held aside so a back-to-back write cannot cut the second beat
      if (take && !req_read)
      begin
        wdata0  <= req_wdata0;
        lane_n0 <= req_lane_n0;
        wdata1  <= req_wdata1;
        lane_n1 <= req_lane_n1;
      end
      if (wr_first)
      begin
        link.dq_ctl_oe          <= 1'b1; // RL1 RL7 RL5
        link.dq_ctl_o           <= wdata0;
        link.byte_lane_strobe_n <= lane_n0;
      end
      else if (wr_second)
      begin
        link.dq_ctl_o           <= wdata1;
        link.byte_lane_strobe_n <= lane_n1;
      end
      else
      begin
        link.dq_ctl_oe          <= 1'b0;
        link.byte_lane_strobe_n <= RST_LANE_N;
      end
    end
  end

  // read beats return a fixed number of cycles after the command beat
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rd_sh     <= RST_SHIFT;
      rsp_valid <= 1'b0;
      rsp_last  <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rd_sh     <= {rd_sh[SH_W-2:0], !link.load_strobe_n && link.read_not_write};
      rsp_valid <= rd_sh[RD_LAT-1] || rd_sh[RD_LAT];
      rsp_last  <= rd_sh[RD_LAT];
      rsp_data  <= link.dq; // RL2
    end
  end
endmodule // ddrb_ctl

// ===== src/ddrb_dev.sv
// sram device end: command decode, burst counter, byte-lane store, ddr read out
`timescale 1ns/1ps
// Overview of operation
// [RL1] write data captured on both input phases
// [RL2] read data on output phases, else input
// [RL3] data outputs released when no read
// [RL4] low load strobe defines address and direction
// [RL5] every access moves exactly two words
// [RL6] direction high reads, low writes
// [RL7] lane strobes sampled with their data beat
// [RL8] inactive lane leaves stored byte unchanged
// [RL9] lane n covers data bits 9n+8..9n
// [RL10] low address bit loads burst counter
// [RL11] shared address, 22 bits wide here
// [RL12] address ignored while deselected
// [RL13] accesses start on true clock edge only
// [RL14] high load strobe means deselect cycle
module ddrb_dev
  import ddrb_pkg::*;
#(
  parameter int AW = STORE_AW
)
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  ddrb_link_if.dev    link,
  input  wire logic   single_clock_mode,
  output logic        access_active
);
  localparam int DEPTH = 1 << AW;

  logic [LANE_W-1:0]  mem_lane [LANES][DEPTH];

  logic               cmd_load;
  logic               cmd_read;
  logic               cmd_write;
  logic               out_true;
  logic               out_comp;

  logic [AW-1:1]      wr_hi;
  logic               wr_cnt;
  logic               wr_first;
  logic               wr_second;
  logic               wr_beat;
  logic [AW-1:0]      wr_idx;

  logic [AW-1:1]      rd_hi;
  logic               rd_cnt;
  logic               rd_pend;
  logic [AW-1:1]      out_hi;
  logic               out_cnt;
  ddrb_out_t          out_state;
  ddrb_out_t          next_out_state;
  logic [AW-1:0]      rd_idx;
  logic [DATA_W-1:0]  rd_word;

  // commands only count on a true-clock beat with the strobe low
  assign cmd_load  = link.k_tick && !link.load_strobe_n; // RL13 RL14 RL4
  assign cmd_read  = cmd_load && link.read_not_write; // RL6
  assign cmd_write = cmd_load && !link.read_not_write; // RL6

  // output beat phases: data clocks, or input clocks in single-clock mode
  assign out_true = single_clock_mode ? link.k_tick : link.c_tick; // RL2
  assign out_comp = single_clock_mode ? link.kn_tick : link.cn_tick; // RL2

  // write command latch and burst counter
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wr_hi     <= '0;
      wr_cnt    <= 1'b0;
      wr_first  <= 1'b0;
      wr_second <= 1'b0;
    end
    else
    begin
      if (link.kn_tick && wr_first)
      begin
        wr_first  <= 1'b0;
        wr_second <= 1'b1;
        wr_cnt    <= ~wr_cnt; // RL10
      end
      else if (link.k_tick && wr_second)
      begin
        wr_second <= 1'b0; // RL5
      end
      if (cmd_write)
      begin
        wr_hi    <= link.addr_hi[AW-1:1]; // RL12 RL11
        wr_cnt   <= link.burst_first_index; // RL10
        wr_first <= 1'b1;
      end
    end
  end

  // one beat on the complementary phase, one on the next true phase
  assign wr_beat = (link.kn_tick && wr_first) || (link.k_tick && wr_second); // RL1 RL5
  assign wr_idx  = {wr_hi, wr_cnt};

  // per-lane store; strobe sampled on the same beat as the data
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    always_ff @(posedge clk_sys)
    begin
      if (wr_beat && !link.byte_lane_strobe_n[g]) // RL7 RL8
      begin
        mem_lane[g][wr_idx] <= link.dq[g*LANE_W +: LANE_W]; // RL9
      end
    end
    assign rd_word[g*LANE_W +: LANE_W] = mem_lane[g][rd_idx]; // RL9
  end

  // read command latch; a new command on the same beat wins
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rd_hi   <= '0;
      rd_cnt  <= 1'b0;
      rd_pend <= 1'b0;
    end
    else
    begin
      if (out_true && rd_pend && !cmd_read)
      begin
        rd_pend <= 1'b0;
      end
      if (cmd_read)
      begin
        rd_hi   <= link.addr_hi[AW-1:1]; // RL12 RL11
        rd_cnt  <= link.burst_first_index; // RL10
        rd_pend <= 1'b1;
      end
    end
  end

  // read word index follows the output beat in flight
  always_comb
  begin
    rd_idx = {rd_hi, rd_cnt};
    if (out_state == DDRB_OUT_FIRST && out_comp)
    begin
      rd_idx = {out_hi, out_cnt};
    end
  end

  // output beat sequencer
  always_comb
  begin
    next_out_state = out_state;
    unique case (out_state)
      DDRB_OUT_IDLE:
      begin
        if (out_true && rd_pend)
        begin
          next_out_state = DDRB_OUT_FIRST;
        end
      end
      DDRB_OUT_FIRST:
      begin
        if (out_comp)
        begin
          next_out_state = DDRB_OUT_SECOND; // RL5
        end
      end
      DDRB_OUT_SECOND:
      begin
        if (out_true)
        begin
          next_out_state = rd_pend ? DDRB_OUT_FIRST : DDRB_OUT_IDLE;
        end
      end
      default:
      begin
        next_out_state = DDRB_OUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      out_state <= DDRB_OUT_IDLE;
      out_hi    <= '0;
      out_cnt   <= 1'b0;
    end
    else
    begin
      out_state <= next_out_state;
      if (out_true && rd_pend)
      begin
        out_hi  <= rd_hi;
        out_cnt <= ~rd_cnt; // RL10
      end
    end
  end

  // data pins: driven only while a read beat is out, released otherwise
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      link.dq_dev_o  <= '0;
      link.dq_dev_oe <= 1'b0;
    end
    else if (out_true)
    begin
      link.dq_dev_oe <= rd_pend; // RL3
      link.dq_dev_o  <= rd_pend ? rd_word : '0; // RL2
    end
    else if (out_comp)
    begin
      link.dq_dev_oe <= (out_state == DDRB_OUT_FIRST); // RL3
      link.dq_dev_o  <= (out_state == DDRB_OUT_FIRST) ? rd_word : '0; // RL2
    end
  end

  // status for the surrounding logic
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      access_active <= 1'b0;
    end
    else
    begin
      access_active <= wr_first || wr_second || rd_pend || (out_state != DDRB_OUT_IDLE);
    end
  end
endmodule // ddrb_dev

// ===== src/ddrb_link_if.sv
// link between the memory controller end and the sram device end
`timescale 1ns/1ps
interface ddrb_link_if
  import ddrb_pkg::*;
();
  logic                k_tick;
  logic                kn_tick;
  logic                c_tick;
  logic                cn_tick;
  logic                load_strobe_n;
  logic                read_not_write;
  logic [ADDR_W-1:1]   addr_hi;
  logic                burst_first_index;
  logic [LANES-1:0]    byte_lane_strobe_n;
  logic [DATA_W-1:0]   dq_ctl_o;
  logic                dq_ctl_oe;
  logic [DATA_W-1:0]   dq_dev_o;
  logic                dq_dev_oe;
  logic [DATA_W-1:0]   dq;

  // shared data wire: device drive wins, otherwise the controller value shows
  assign dq = dq_dev_oe ? dq_dev_o : dq_ctl_o;

  modport ctl (
    output k_tick, kn_tick, c_tick, cn_tick, load_strobe_n, read_not_write,
    output addr_hi, burst_first_index, byte_lane_strobe_n, dq_ctl_o, dq_ctl_oe,
    input  dq
  );

  modport dev (
    input  k_tick, kn_tick, c_tick, cn_tick, load_strobe_n, read_not_write,
    input  addr_hi, burst_first_index, byte_lane_strobe_n, dq,
    output dq_dev_o, dq_dev_oe
  );
endinterface

// ===== src/ddrb_pkg.sv
// shared constants and types for the two-word-burst ddr sram port
package ddrb_pkg;
  localparam int DATA_W    = 36;
  localparam int LANE_W    = 9;
  localparam int LANES     = 4;
  localparam int ADDR_W    = 22;
  localparam int BURST_LEN = 2;
  localparam int STORE_AW  = 10;
  localparam int RD_LAT    = 3;
  localparam int SH_W      = 5;

  localparam logic       RST_STROBE_N   = 1'h1;
  localparam logic       RST_RNW        = 1'h0;
  localparam logic       RST_TICK       = 1'h0;
  localparam logic [3:0] RST_LANE_N     = 4'hF;
  localparam logic [4:0] RST_SHIFT      = 5'h00;

  typedef enum logic [1:0] {
    DDRB_OUT_IDLE   = 2'b00,
    DDRB_OUT_FIRST  = 2'b01,
    DDRB_OUT_SECOND = 2'b11
  } ddrb_out_t;
endpackage
